// file: rtl/adc_pkg.sv
package adc_pkg;

    // Register map (byte addresses on the plain register port)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PULLDOWN = 8'h02;
    localparam logic [7:0] OFS_START = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h06;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] PULLDOWN_RESET = 16'h0000;
    localparam logic [3:0] CHSEL_RESET = 4'h0;

    // Start register layout: channel select in [3:0], start bit at 5
    localparam int START_BIT = 5;
    localparam int CHSEL_LSB = 0;
    // Status layout: current channel [3:0], scan mode 6, busy 7
    localparam int STAT_SCAN_BIT = 6;
    localparam int STAT_BUSY_BIT = 7;

    // Trigger select encodings
    localparam logic [1:0] TRIG_OFF = 2'h0;
    localparam logic [1:0] TRIG_TIMER = 2'h1;
    localparam logic [1:0] TRIG_BAD = 2'h2;
    localparam logic [1:0] TRIG_EXT = 2'h3;

    // Conversion times in states; one state is one CLK_IN cycle
    localparam int STATE_CYCLES = 1;
    localparam int TCONV_MAX_STATES_0 = 530;
    localparam int TCONV_MAX_STATES_1 = 266;
    localparam int TCONV_MAX_STATES_2 = 134;
    localparam int TCONV_MAX_STATES_3 = 68;
    localparam int TSCAN_STATES_0 = 512;
    localparam int TSCAN_STATES_1 = 256;
    localparam int TSCAN_STATES_2 = 128;
    localparam int TSCAN_STATES_3 = 64;
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] FIRST_CYC_0 =
        CNT_W'(TCONV_MAX_STATES_0 * STATE_CYCLES);
    localparam logic [CNT_W-1:0] FIRST_CYC_1 =
        CNT_W'(TCONV_MAX_STATES_1 * STATE_CYCLES);
    localparam logic [CNT_W-1:0] FIRST_CYC_2 =
        CNT_W'(TCONV_MAX_STATES_2 * STATE_CYCLES);
    localparam logic [CNT_W-1:0] FIRST_CYC_3 =
        CNT_W'(TCONV_MAX_STATES_3 * STATE_CYCLES);
    localparam logic [CNT_W-1:0] SCAN_CYC_0 =
        CNT_W'(TSCAN_STATES_0 * STATE_CYCLES);
    localparam logic [CNT_W-1:0] SCAN_CYC_1 =
        CNT_W'(TSCAN_STATES_1 * STATE_CYCLES);
    localparam logic [CNT_W-1:0] SCAN_CYC_2 =
        CNT_W'(TSCAN_STATES_2 * STATE_CYCLES);
    localparam logic [CNT_W-1:0] SCAN_CYC_3 =
        CNT_W'(TSCAN_STATES_3 * STATE_CYCLES);

    typedef struct packed {
        logic [1:0] trig_sel;
        logic scan_enable_bit;
        logic scan_size_bit;
        logic [1:0] conv_clock_select;
        logic [1:0] zero;
    } ctrl_t;

    typedef struct packed {
        logic done;
        logic group_done;
        logic [3:0] chan;
    } conv_event_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } seq_state_t;

endpackage

// file: rtl/conv_timer.sv
`timescale 1ns/1ps
module conv_timer
    import adc_pkg::*;
#(
    parameter int W = CNT_W
)
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic load_in,
    input wire logic [W-1:0] count_in,
    input wire logic abort_in,
    output logic done_out,
    output logic busy_out
);
    logic [W-1:0] cnt_q;
    logic busy_q;
    logic last;

    assign last = busy_q && (cnt_q == W'(1));
    assign done_out = last && !abort_in;
    assign busy_out = busy_q;

    // A load in the cycle of done chains straight into the next channel
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            cnt_q <= '0;
            busy_q <= 1'b0;
        end
        else if (load_in)
        begin
            cnt_q <= count_in;
            busy_q <= 1'b1;
        end
        else if (abort_in || last)
        begin
            busy_q <= 1'b0;
        end
        else if (busy_q)
        begin
            cnt_q <= cnt_q - W'(1);
        end
    end
endmodule

// file: rtl/trigger_select.sv
`timescale 1ns/1ps
module trigger_select
    import adc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [1:0] trig_sel_in,
    input wire logic timer_trig_in,
    input wire logic ext_trig_n_in,
    output logic start_out
);
    logic ext_prev_q;
    logic ext_fall;

    // Reset to high, so a pin held low out of reset counts as a falling edge in the first cycle
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            ext_prev_q <= 1'b1;
        else
            ext_prev_q <= ext_trig_n_in;
    end

    assign ext_fall = ext_prev_q && !ext_trig_n_in;
    // The prohibited code 10 acts as disabled
    assign start_out = ((trig_sel_in == TRIG_TIMER) && timer_trig_in) ||
                       ((trig_sel_in == TRIG_EXT) && ext_fall);
endmodule

// file: rtl/adc_control.sv
// Operation
// - Trigger select 00 disables triggers, 01 takes the timer unit, 10 is prohibited, 11 takes the falling edge of the external pin.
// - With the scan-enable bit clear the converter runs in single mode regardless of the scan-size bit.
// - Scan-enable set with scan-size clear converts a group of up to four channels in a repeating loop.
// - Scan-enable and scan-size both set convert a group of up to eight channels in a repeating loop.
// - Clock select 00 gives at most 530 states per conversion and 01 at most 266 states.
// - Clock select 10 gives at most 134 states per conversion and 11 at most 68 states.
// - Bits 1 and 0 of the control register read as zero and ignore writes.
// - Each of the sixteen pull-down bits switches the pull-down of its own analog pin, 1 on and 0 off.
// - Writing 1 to the start bit starts and 0 stops; single mode clears it at the end, scan mode keeps it.
// - Channel select together with the mode picks the single channel or the scan group.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module adc_control
    import adc_pkg::*;
#(
    parameter int PINS = 16
)
(
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    input wire logic [7:0] ADDR_IN,
    input wire logic [15:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [15:0] RDATA_OUT,
    input wire logic TIMER_TRIG_IN,
    input wire logic EXT_TRIG_N_IN,
    output logic [PINS-1:0] PULLDOWN_OUT,
    output logic CONVERTING_OUT,
    output logic [3:0] CHANNEL_OUT,
    output logic CHAN_DONE_OUT,
    output logic GROUP_DONE_OUT,
    output logic [3:0] DONE_CHAN_OUT
);
    ctrl_t ctrl_q;
    ctrl_t ctrl_d;
    logic [PINS-1:0] pd_q;
    logic [3:0] chsel_q;
    logic start_q;
    logic start_d;
    seq_state_t state_q;
    seq_state_t state_d;
    logic [3:0] chan_q;
    logic [3:0] chan_d;
    conv_event_t evt_q;
    logic [15:0] rdata_q;

    logic wr_ctrl;
    logic wr_pd;
    logic wr_start;
    logic trig_start;
    logic sw_set;
    logic sw_clr;
    logic single_end;
    logic scan_on;
    logic scan8;
    logic [3:0] first_chan;
    logic [3:0] last_chan;
    logic at_last;
    logic enter;
    logic advance;
    logic abort;
    logic tmr_load;
    logic tmr_done;
    logic [CNT_W-1:0] tmr_count;
    logic [15:0] rd_mux;

    function automatic logic [CNT_W-1:0] conv_cycles(
        input logic [1:0] cks,
        input logic first
    );
        logic [CNT_W-1:0] c;
        c = '0;
        unique case (cks)
            2'h0: c = first ? FIRST_CYC_0 : SCAN_CYC_0;
            2'h1: c = first ? FIRST_CYC_1 : SCAN_CYC_1;
            2'h2: c = first ? FIRST_CYC_2 : SCAN_CYC_2;
            2'h3: c = first ? FIRST_CYC_3 : SCAN_CYC_3;
        endcase
        return c;
    endfunction

    // Register decode
    assign wr_ctrl = WR_IN && (ADDR_IN == OFS_CTRL);
    assign wr_pd = WR_IN && (ADDR_IN == OFS_PULLDOWN);
    assign wr_start = WR_IN && (ADDR_IN == OFS_START);
    assign sw_set = wr_start && WDATA_IN[START_BIT];
    assign sw_clr = wr_start && !WDATA_IN[START_BIT];

    assign ctrl_d = wr_ctrl ? ctrl_t'({WDATA_IN[7:2], 2'b00}) : ctrl_q;

    trigger_select u_trig (
        .clk_in(CLK_IN),
        .rstn_in(RSTN_IN),
        .trig_sel_in(ctrl_q.trig_sel),
        .timer_trig_in(TIMER_TRIG_IN),
        .ext_trig_n_in(EXT_TRIG_N_IN),
        .start_out(trig_start)
    );

    // Mode and group decode
    assign scan_on = ctrl_q.scan_enable_bit;
    assign scan8 = ctrl_q.scan_enable_bit && ctrl_q.scan_size_bit;
    assign first_chan = !scan_on ? chsel_q :
                        scan8 ? {chsel_q[3], 3'b000} :
                        {chsel_q[3:2], 2'b00};
    assign last_chan = chsel_q;
    assign at_last = (chan_q == last_chan);

    // Sequencer
    assign enter = (state_q == ST_IDLE) && start_q;
    assign abort = (state_q == ST_CONV) && !start_q;
    assign advance = tmr_done && scan_on && !abort;
    assign single_end = tmr_done && !scan_on;
    assign tmr_load = enter || advance;
    // Clock select is sampled at each load, relying on it being
    // stable while the start bit is set
    assign tmr_count = conv_cycles(ctrl_q.conv_clock_select, enter);

    always_comb
    begin
        state_d = state_q;
        chan_d = chan_q;
        unique case (state_q)
            ST_IDLE:
            begin
                if (start_q)
                begin
                    state_d = ST_CONV;
                    chan_d = first_chan;
                end
            end
            ST_CONV:
            begin
                if (abort || single_end)
                    state_d = ST_IDLE;
                else if (advance)
                    chan_d = at_last ? first_chan : chan_q + 4'h1;
            end
        endcase
    end

    // A set in the same cycle as a clear wins
    assign start_d = (sw_set || trig_start) ? 1'b1 :
                     (sw_clr || single_end) ? 1'b0 : start_q;

    conv_timer #(
        .W(CNT_W)
    ) u_timer (
        .clk_in(CLK_IN),
        .rstn_in(RSTN_IN),
        .load_in(tmr_load),
        .count_in(tmr_count),
        .abort_in(abort),
        .done_out(tmr_done),
        .busy_out()
    );

    // Read mux
    assign rd_mux =
        (ADDR_IN == OFS_CTRL) ? {8'h00, ctrl_q} :
        (ADDR_IN == OFS_PULLDOWN) ? 16'(pd_q) :
        (ADDR_IN == OFS_START) ? {10'h000, start_q, 1'b0, chsel_q} :
        (ADDR_IN == OFS_STATUS) ? {8'h00, state_q == ST_CONV, scan_on,
                                   2'b00, chan_q} :
        16'h0000;

    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            ctrl_q <= ctrl_t'(CTRL_RESET);
            pd_q <= PINS'(PULLDOWN_RESET);
            chsel_q <= CHSEL_RESET;
            start_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            if (wr_pd)
                pd_q <= WDATA_IN[PINS-1:0];
            if (wr_start)
                chsel_q <= WDATA_IN[CHSEL_LSB +: 4];
            start_q <= start_d;
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            state_q <= ST_IDLE;
            chan_q <= 4'h0;
        end
        else
        begin
            state_q <= state_d;
            chan_q <= chan_d;
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            evt_q <= '0;
            rdata_q <= 16'h0000;
        end
        else
        begin
            evt_q.done <= tmr_done;
            evt_q.group_done <= tmr_done && (!scan_on || at_last);
            evt_q.chan <= tmr_done ? chan_q : evt_q.chan;
            rdata_q <= RD_IN ? rd_mux : 16'h0000;
        end
    end

    assign RDATA_OUT = rdata_q;
    assign PULLDOWN_OUT = pd_q;
    assign CONVERTING_OUT = (state_q == ST_CONV);
    assign CHANNEL_OUT = chan_q;
    assign CHAN_DONE_OUT = evt_q.done;
    assign GROUP_DONE_OUT = evt_q.group_done;
    assign DONE_CHAN_OUT = evt_q.chan;
endmodule

// file: testbench/adc_control_properties.sv
`timescale 1ns/1ps
module adc_control_checker
    import adc_pkg::*;
#(
    parameter int PINS = 16
)
(
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    input wire logic [7:0] ADDR_IN,
    input wire logic [15:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic [15:0] RDATA_OUT,
    input wire logic TIMER_TRIG_IN,
    input wire logic EXT_TRIG_N_IN,
    input wire logic [PINS-1:0] PULLDOWN_OUT,
    input wire logic CONVERTING_OUT,
    input wire logic [3:0] CHANNEL_OUT,
    input wire logic CHAN_DONE_OUT,
    input wire logic GROUP_DONE_OUT,
    input wire logic [3:0] DONE_CHAN_OUT
);
    logic [7:0] ctrl_q;
    logic [3:0] chsel_q;
    logic [9:0] cnt_q;
    logic first_q;
    wire [9:0] first_cyc = ctrl_q[3] ? (ctrl_q[2] ? 10'h044 : 10'h086)
        : (ctrl_q[2] ? 10'h10a : 10'h212);
    wire [9:0] scan_cyc = 10'h200 >> ctrl_q[3:2];
    default clocking @(posedge CLK_IN);
    endclocking
    default disable iff (!RSTN_IN);
    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            ctrl_q <= 8'h00;
            chsel_q <= 4'h0;
        end
        else if (WR_IN && ADDR_IN == OFS_CTRL)
            ctrl_q <= WDATA_IN[7:0] & 8'hfc;
        else if (WR_IN && ADDR_IN == OFS_START)
            chsel_q <= WDATA_IN[3:0];
    end
    // Chained scan channels restart the count, so first and later differ
    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN || !CONVERTING_OUT)
        begin
            cnt_q <= 10'h000;
            first_q <= 1'b1;
        end
        else
        begin
            cnt_q <= CHAN_DONE_OUT ? 10'h001 : cnt_q + 10'h001;
            first_q <= first_q && !CHAN_DONE_OUT;
        end
    end
    AST_CTRL_READ: assert property (
        RD_IN && ADDR_IN == OFS_CTRL |=> RDATA_OUT == {8'h00, ctrl_q})
        else $error("control read wrong");
    AST_PD_WRITE: assert property (
        WR_IN && ADDR_IN == OFS_PULLDOWN |=> PULLDOWN_OUT == $past(WDATA_IN))
        else $error("pull-down write lost");
    AST_PD_READ: assert property (
        RD_IN && ADDR_IN == OFS_PULLDOWN |=> RDATA_OUT == PULLDOWN_OUT)
        else $error("pull-down read wrong");
    AST_FIRST_TIME: assert property (
        CHAN_DONE_OUT && first_q |-> cnt_q == first_cyc)
        else $error("first conversion time wrong");
    AST_SCAN_TIME: assert property (
        CHAN_DONE_OUT && !first_q |-> cnt_q == scan_cyc)
        else $error("scan conversion time wrong");
    AST_SINGLE_END: assert property (
        CHAN_DONE_OUT && !ctrl_q[5] |-> GROUP_DONE_OUT && !CONVERTING_OUT
        && DONE_CHAN_OUT == chsel_q) else $error("single end wrong");
    AST_GROUP_END: assert property (
        CHAN_DONE_OUT && ctrl_q[5] |-> CONVERTING_OUT
        && GROUP_DONE_OUT == (DONE_CHAN_OUT == chsel_q))
        else $error("scan group end wrong");
    AST_SCAN_SPAN: assert property (
        CONVERTING_OUT && ctrl_q[5] |-> CHANNEL_OUT <= chsel_q
        && (ctrl_q[4] ? CHANNEL_OUT[3] == chsel_q[3]
        : CHANNEL_OUT[3:2] == chsel_q[3:2])) else $error("scan channel out");
    AST_STOP: assert property (
        WR_IN && ADDR_IN == OFS_START && !WDATA_IN[START_BIT] && !TIMER_TRIG_IN
        && !$fell(EXT_TRIG_N_IN) |=> ##1 !CONVERTING_OUT)
        else $error("stop ignored");
    AST_TRIG_IGNORED: assert property (
        (TIMER_TRIG_IN || $fell(EXT_TRIG_N_IN)) && !ctrl_q[6] && !CONVERTING_OUT
        && !WR_IN && !$past(WR_IN) |=> ##1 !CONVERTING_OUT)
        else $error("trigger not ignored");
    AST_TIMER_START: assert property (
        TIMER_TRIG_IN && ctrl_q[7:6] == TRIG_TIMER && !WR_IN
        |=> ##1 CONVERTING_OUT) else $error("timer trigger missed");
    AST_EXT_START: assert property (
        $fell(EXT_TRIG_N_IN) && ctrl_q[7:6] == TRIG_EXT && !WR_IN
        |=> ##1 CONVERTING_OUT) else $error("pin trigger missed");
    cover property (CHAN_DONE_OUT && !ctrl_q[5]);
    cover property (GROUP_DONE_OUT && ctrl_q[4]);
    cover property ($fell(CONVERTING_OUT) && !CHAN_DONE_OUT);
endmodule
bind adc_control adc_control_checker #(.PINS(PINS)) u_adc_control_checker (
    .CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
    .TIMER_TRIG_IN(TIMER_TRIG_IN), .EXT_TRIG_N_IN(EXT_TRIG_N_IN),
    .PULLDOWN_OUT(PULLDOWN_OUT), .CONVERTING_OUT(CONVERTING_OUT),
    .CHANNEL_OUT(CHANNEL_OUT), .CHAN_DONE_OUT(CHAN_DONE_OUT),
    .GROUP_DONE_OUT(GROUP_DONE_OUT), .DONE_CHAN_OUT(DONE_CHAN_OUT));

// file: testbench/trigger_source.sv
`timescale 1ns/1ps
module trigger_source
(
    input wire logic clk_in,
    output logic timer_trig_out = 1'b0,
    output logic ext_trig_n_out = 1'b1
);
    // Both sources fire together; only the selected one may count
    task automatic fire(input int low_cycles);
        @(posedge clk_in);
        timer_trig_out <= 1'b1;
        ext_trig_n_out <= 1'b0;
        @(posedge clk_in);
        timer_trig_out <= 1'b0;
        repeat (low_cycles) @(posedge clk_in);
        ext_trig_n_out <= 1'b1;
    endtask
endmodule

// file: testbench/adc_control_tb_top.sv
`timescale 1ns/1ps
module adc_control_tb_top
    import adc_pkg::*;
;
    logic CLK_IN = 1'b0;
    logic RSTN_IN = 1'b0;
    logic [7:0] ADDR_IN = 8'h00;
    logic [15:0] WDATA_IN = 16'h0000;
    logic WR_IN = 1'b0;
    logic RD_IN = 1'b0;
    logic [15:0] RDATA_OUT, PULLDOWN_OUT;
    logic TIMER_TRIG_IN, EXT_TRIG_N_IN, CONVERTING_OUT;
    logic CHAN_DONE_OUT, GROUP_DONE_OUT;
    logic [3:0] CHANNEL_OUT, DONE_CHAN_OUT;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    int seed = 32'h341b;
    always #5 CLK_IN = ~CLK_IN;
    adc_control u_adc_control (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN),
        .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
        .RDATA_OUT(RDATA_OUT), .TIMER_TRIG_IN(TIMER_TRIG_IN),
        .EXT_TRIG_N_IN(EXT_TRIG_N_IN), .PULLDOWN_OUT(PULLDOWN_OUT),
        .CONVERTING_OUT(CONVERTING_OUT), .CHANNEL_OUT(CHANNEL_OUT),
        .CHAN_DONE_OUT(CHAN_DONE_OUT), .GROUP_DONE_OUT(GROUP_DONE_OUT),
        .DONE_CHAN_OUT(DONE_CHAN_OUT));
    trigger_source u_trigger_source (.clk_in(CLK_IN),
        .timer_trig_out(TIMER_TRIG_IN), .ext_trig_n_out(EXT_TRIG_N_IN));
    function automatic logic [15:0] tconv(input logic [1:0] c);
        return c[1] ? (c[0] ? 16'h0044 : 16'h0086)
            : (c[0] ? 16'h010a : 16'h0212);
    endfunction
    task automatic wrap_up;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge CLK_IN);
        ADDR_IN <= a;
        WDATA_IN <= d;
        WR_IN <= 1'b1;
        @(posedge CLK_IN);
        WR_IN <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
        @(posedge CLK_IN);
        ADDR_IN <= a;
        RD_IN <= 1'b1;
        @(posedge CLK_IN);
        RD_IN <= 1'b0;
        #1 chk(RDATA_OUT, exp);
    endtask
    // Counts cycles until the next channel-done pulse, bounded
    task automatic run(output logic [15:0] n);
        n = 16'h0000;
        do
        begin
            @(posedge CLK_IN);
            #1 n++;
        end while (CHAN_DONE_OUT !== 1'b1 && n < 16'h07d0);
    endtask
    always @(posedge CLK_IN)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            wrap_up();
        end
    end
    initial
    begin
        logic [15:0] d, n;
        logic [3:0] cs, f;
        repeat (2) @(posedge CLK_IN);
        RSTN_IN <= 1'b1;
        rdc(OFS_CTRL, 16'h0000);
        for (int i = 0; i < 6; i++)
        begin
            d = (i == 0) ? 16'hffff : 16'($random(seed));
            wr(OFS_PULLDOWN, d);
            chk(PULLDOWN_OUT, d);
            rdc(OFS_PULLDOWN, d);
            wr(OFS_CTRL, d);
            rdc(OFS_CTRL, {8'h00, d[7:2], 2'b00});
        end
        wr(8'h0e, 16'hffff);
        rdc(8'h0e, 16'h0000);
        for (int c = 0; c < 4; c++)
        begin
            cs = 4'($random(seed)) & 4'h7;
            wr(OFS_CTRL, 16'(c * 4 + 16));
            wr(OFS_START, 16'h0020 | 16'(cs));
            run(n);
            chk(n, tconv(2'(c)) + 16'd1);
            chk(16'(DONE_CHAN_OUT), 16'(cs));
            rdc(OFS_START, 16'(cs));
        end
        for (int j = 0; j < 2; j++)
        begin
            cs = j ? 4'hb : 4'h6;
            f = j ? (cs & 4'h8) : (cs & 4'hc);
            wr(OFS_CTRL, j ? 16'h003c : 16'h002c);
            wr(OFS_START, 16'h0020 | 16'(cs));
            for (int k = 0; k < 2 * (cs - f + 1); k++)
            begin
                run(n);
                d = 16'(f) + 16'(k % (cs - f + 1));
                chk(16'(DONE_CHAN_OUT), d);
                chk(16'(GROUP_DONE_OUT), 16'(d == 16'(cs)));
            end
            wr(OFS_START, 16'(cs));
            @(posedge CLK_IN);
            #1 chk(16'(CONVERTING_OUT), 16'h0000);
        end
        wr(OFS_START, 16'h0002);
        for (int t = 0; t < 4; t++)
        begin
            wr(OFS_CTRL, 16'(t * 64 + 12));
            u_trigger_source.fire(3);
            #1 chk(16'(CONVERTING_OUT), 16'(t % 2));
            if (t % 2)
            begin
                run(n);
                chk(16'(DONE_CHAN_OUT), 16'h0002);
            end
        end
        // Reset is driven on the clock edge like every other input
        @(posedge CLK_IN);
        RSTN_IN <= 1'b0;
        repeat (2) @(posedge CLK_IN);
        RSTN_IN <= 1'b1;
        rdc(OFS_PULLDOWN, 16'h0000);
        rdc(OFS_CTRL, 16'h0000);
        rdc(OFS_STATUS, 16'h0000);
        rdc(OFS_START, 16'h0000);
        wrap_up();
    end
endmodule
